// ---- rtl/oim_irq_mask.sv ----
// oim_irq_mask: interrupt enable mask with set and clear ports, plus request output
// the mask is one shared word; the set port ors ones in, the clear port knocks ones out
// assumes a simple synchronous register port, one access per cycle, events as levels
// assumes the event flag register sits outside and hands its flags over as levels
// Notes on behaviour
// [R1] master gate bit 31 lets enabled events interrupt; zero blocks all
// [R2] bit 30 enables owner change event interrupt
// [R3] bit 6 enables root status change event interrupt
// [R4] bit 5 enables frame count wrap event interrupt
// [R5] bit 4 enables fatal system error event interrupt
// [R6] bit 3 enables wakeup signal seen event interrupt
// [R7] bit 2 enables frame begin event interrupt
// [R8] bit 1 enables done list written event interrupt
// [R9] bit 0 enables schedule overrun event interrupt
// [R10] writing ones to clear port at 14h clears those mask bits
// [R11] clear port reads the mask, same as set port, without side effects
// [R12] software writes zero into reserved bits 29 to 7
// [R13] mask is all zero after reset
// [R14] request needs flag, its enable and master gate together
// [R15] writing ones to set port at 10h sets those mask bits
// [R16] software clears event flags by writing one; cannot set them
// [R17] request is a level held while any gated enabled flag remains
`timescale 1ns/1ps
`default_nettype none
module oim_irq_mask
    import oim_pkg::*;
#(
    parameter int NUM_EVENTS = oim_pkg::OIM_NUM_EVENTS
) (
    // clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_b_i,

    // register port
    input  wire logic                          reg_sel_i,
    input  wire logic                          reg_wr_i,
    input  wire logic [oim_pkg::OIM_ADDR_W-1:0] reg_addr_i,
    input  wire logic [oim_pkg::OIM_DATA_W-1:0] reg_wdata_i,
    output logic      [oim_pkg::OIM_DATA_W-1:0] reg_rdata_o,
    output logic                               reg_hit_o,

    // event flag levels
    input  wire logic                          owner_change_event_i,
    input  wire logic [NUM_EVENTS-2:0]         irq_event_flags_i,

    // mask and request
    output logic      [oim_pkg::OIM_DATA_W-1:0] irq_mask_o,
    output logic                               irq_req_o
);
    import oim_pkg::*;

    // timing of one access, edge by edge:
    //   edge n   : request taken while reg_sel_i is high
    //   edge n   : reg_hit_o pulses, read data stands, a written mask is visible
    //   edge n+1 : irq_req_o follows the new mask
    // flag inputs are levels; irq_req_o follows them one edge later
    // no byte enables: every write moves the whole word
    // reserved places of the mask hold zero whatever is written
    // the clear port reads exactly what the set port reads
    // the request pin is a flop, so it cannot glitch on bus activity

    typedef struct packed {
        logic [OIM_DATA_W-1:0] mask;
        logic [OIM_DATA_W-1:0] rdata;
        logic                  hit;
        logic                  irq;
    } oim_state_s;

    oim_state_s state_ff;
    oim_state_s nxt_state;

    // access decode terms
    logic                  addr_set;
    logic                  addr_clr;
    logic                  wr_cycle;
    logic                  rd_cycle;
    logic                  set_wr;
    logic                  clr_wr;
    logic                  rd_hit;

    // per-bit mask update terms
    logic [OIM_DATA_W-1:0] set_bits;
    logic [OIM_DATA_W-1:0] clr_bits;
    logic [OIM_DATA_W-1:0] mask_upd;

    // named enables: master gate, then one per event
    logic                  en_master;
    logic                  en_owner_chg;
    logic                  en_root_stat;
    logic                  en_frame_wrap;
    logic                  en_fatal_err;
    logic                  en_wakeup;
    logic                  en_frame_begin;
    logic                  en_done_list;
    logic                  en_sched_ovr;

    // named flag levels, one per event
    logic                  fl_owner_chg;
    logic                  fl_root_stat;
    logic                  fl_frame_wrap;
    logic                  fl_fatal_err;
    logic                  fl_wakeup;
    logic                  fl_frame_begin;
    logic                  fl_done_list;
    logic                  fl_sched_ovr;

    // gate inputs and result
    logic [NUM_EVENTS-1:0] flags;
    logic [NUM_EVENTS-1:0] enables;
    logic                  req_comb;

    // refused accesses:
    //   writes to any other offset change nothing
    //   reads of any other offset return zero, reg_hit_o still pulses
    //   set port writes drop reserved places; clear port writes there do no harm

    // address match, shared by read and write
    assign addr_set = (reg_addr_i == OIM_OFS_SET_PORT);
    assign addr_clr = (reg_addr_i == OIM_OFS_CLEAR_PORT);

    // cycle kind; reg_wr_i only counts while reg_sel_i is high
    assign wr_cycle = reg_sel_i & reg_wr_i;
    assign rd_cycle = reg_sel_i & ~reg_wr_i;

    // port strobes; other offsets fall through untouched
    assign set_wr = wr_cycle & addr_set; // [R15]
    assign clr_wr = wr_cycle & addr_clr; // [R10]
    assign rd_hit = rd_cycle & (addr_set | addr_clr); // [R11]

    // per-bit mask update: set-port ones go in, clear-port ones go out
    // the two strobes never meet in one cycle, so neither needs priority
    genvar gb;
    generate
        for (gb = 0; gb < OIM_DATA_W; gb++) begin : g_bit
            if (OIM_IMPL_MASK[gb]) begin : g_impl
                assign set_bits[gb] = set_wr & reg_wdata_i[gb]; // [R15]
            end else begin : g_rsvd
                // reserved place: a stray one from software never sticks
                assign set_bits[gb] = 1'b0; // [R12]
            end
            assign clr_bits[gb] = clr_wr & reg_wdata_i[gb]; // [R10]
            assign mask_upd[gb] = set_bits[gb] | (state_ff.mask[gb] & ~clr_bits[gb]);
        end
    endgenerate

    // named view of the master gate
    assign en_master      = state_ff.mask[OIM_BIT_MASTER_GATE]; // [R1]

    // named view of the event enables
    assign en_owner_chg   = state_ff.mask[OIM_BIT_OWNER_CHG];   // [R2]
    assign en_root_stat   = state_ff.mask[OIM_BIT_ROOT_STAT];   // [R3]
    assign en_frame_wrap  = state_ff.mask[OIM_BIT_FRAME_WRAP];  // [R4]
    assign en_fatal_err   = state_ff.mask[OIM_BIT_FATAL_ERR];   // [R5]
    assign en_wakeup      = state_ff.mask[OIM_BIT_WAKEUP];      // [R6]
    assign en_frame_begin = state_ff.mask[OIM_BIT_FRAME_BEGIN]; // [R7]
    assign en_done_list   = state_ff.mask[OIM_BIT_DONE_LIST];   // [R8]
    assign en_sched_ovr   = state_ff.mask[OIM_BIT_SCHED_OVR];   // [R9]

    // named view of the flag levels; clearing them is up to software
    assign fl_owner_chg   = owner_change_event_i;
    assign fl_root_stat   = irq_event_flags_i[OIM_BIT_ROOT_STAT];
    assign fl_frame_wrap  = irq_event_flags_i[OIM_BIT_FRAME_WRAP];
    assign fl_fatal_err   = irq_event_flags_i[OIM_BIT_FATAL_ERR];
    assign fl_wakeup      = irq_event_flags_i[OIM_BIT_WAKEUP];
    assign fl_frame_begin = irq_event_flags_i[OIM_BIT_FRAME_BEGIN];
    assign fl_done_list   = irq_event_flags_i[OIM_BIT_DONE_LIST];
    assign fl_sched_ovr   = irq_event_flags_i[OIM_BIT_SCHED_OVR];

    // event vector: owner change on top, frame events below
    assign flags   = {fl_owner_chg, fl_root_stat, fl_frame_wrap, fl_fatal_err,
                      fl_wakeup, fl_frame_begin, fl_done_list, fl_sched_ovr};
    assign enables = {en_owner_chg, en_root_stat, en_frame_wrap, en_fatal_err,
                      en_wakeup, en_frame_begin, en_done_list, en_sched_ovr};

    // qualification of flags against enables and gate
    // the gate is plain logic; its result is registered in the state word
    // so irq_req_o comes from a flop, at the cost of one cycle of lag
    // after software clears the last flag the pin falls one edge later
    oim_gate #(
        .NUM_EVENTS (NUM_EVENTS)
    ) u_gate (
        .flags_i       (flags),
        .enables_i     (enables),
        .master_gate_i (en_master),
        .irq_req_o     (req_comb)
    );

    // next-state logic
    always_comb begin
        nxt_state = state_ff;
        // mask: ones from the set port in, ones from the clear port out
        nxt_state.mask  = mask_upd; // [R10] [R15]
        // both ports read the mask, no side effect
        nxt_state.rdata = rd_hit ? state_ff.mask : OIM_RDATA_RESET; // [R11]
        // hit echoes every strobe, mapped offset or not
        nxt_state.hit   = reg_sel_i;
        // request held as a level while any gated enabled flag stands
        nxt_state.irq   = req_comb; // [R17]
    end

    // state register
    // reset clears the whole word, so the gate and every enable start off
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_ff.mask  <= OIM_MASK_RESET; // [R13]
            state_ff.rdata <= OIM_RDATA_RESET;
            state_ff.hit   <= 1'b0;
            state_ff.irq   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // every output comes straight from the state register
    // read data is zero outside the cycle after a read
    assign reg_rdata_o = state_ff.rdata;
    assign reg_hit_o   = state_ff.hit;
    assign irq_mask_o  = state_ff.mask;
    assign irq_req_o   = state_ff.irq;
endmodule : oim_irq_mask
`default_nettype wire

// ---- rtl/oim_pkg.sv ----
// oim_pkg: constants for the interrupt mask block of the full-speed host core
// assumes a 32-bit register port with word offsets as byte addresses
package oim_pkg;
    localparam int          OIM_DATA_W          = 32;
    localparam int          OIM_ADDR_W          = 8;
    localparam int          OIM_NUM_EVENTS      = 8;
    // register offsets
    localparam logic [7:0]  OIM_OFS_SET_PORT    = 8'h10;
    localparam logic [7:0]  OIM_OFS_CLEAR_PORT  = 8'h14;
    // field positions
    localparam int          OIM_BIT_MASTER_GATE = 31;
    localparam int          OIM_BIT_OWNER_CHG   = 30;
    localparam int          OIM_BIT_ROOT_STAT   = 6;
    localparam int          OIM_BIT_FRAME_WRAP  = 5;
    localparam int          OIM_BIT_FATAL_ERR   = 4;
    localparam int          OIM_BIT_WAKEUP      = 3;
    localparam int          OIM_BIT_FRAME_BEGIN = 2;
    localparam int          OIM_BIT_DONE_LIST   = 1;
    localparam int          OIM_BIT_SCHED_OVR   = 0;
    // implemented bits: 31, 30 and 6..0; reserved bits read zero
    localparam logic [31:0] OIM_IMPL_MASK       = 32'hc000_007f;
    localparam logic [31:0] OIM_MASK_RESET      = 32'h0000_0000;
    localparam logic [31:0] OIM_RDATA_RESET     = 32'h0000_0000;
endpackage : oim_pkg

// ---- rtl/oim_gate.sv ----
// oim_gate: combines event flags with enables and master gate into one request
// assumes flags and mask are registered in the caller's clock domain
`timescale 1ns/1ps
`default_nettype none
module oim_gate #(
    parameter int NUM_EVENTS = 8
) (
    input  wire logic [NUM_EVENTS-1:0] flags_i,
    input  wire logic [NUM_EVENTS-1:0] enables_i,
    input  wire logic                  master_gate_i,
    output logic                       irq_req_o
);
    logic [NUM_EVENTS-1:0] hit;

    // per-event qualification
    genvar g;
    generate
        for (g = 0; g < NUM_EVENTS; g++) begin : g_evt
            assign hit[g] = flags_i[g] & enables_i[g]; // [R2] [R3] [R4] [R5] [R6] [R7] [R8] [R9]
        end
    endgenerate

    // all three conditions at once
    assign irq_req_o = master_gate_i & (|hit); // [R1] [R14]
endmodule : oim_gate
`default_nettype wire

// ---- verification/oim_irq_mask_props.sv ----
// oim_irq_mask_props: assertions on mask ports and request
// assumes one clock, async low reset, bound into oim_irq_mask
`timescale 1ns/1ps
`default_nettype none
module oim_irq_mask_props
    import oim_pkg::*;
#(
    parameter int NUM_EVENTS = OIM_NUM_EVENTS
) (
    input wire logic                  clk_i,
    input wire logic                  rst_b_i,
    input wire logic                  reg_sel_i,
    input wire logic                  reg_wr_i,
    input wire logic [7:0]            reg_addr_i,
    input wire logic [31:0]           reg_wdata_i,
    input wire logic [31:0]           reg_rdata_o,
    input wire logic                  reg_hit_o,
    input wire logic                  owner_change_event_i,
    input wire logic [NUM_EVENTS-2:0] irq_event_flags_i,
    input wire logic [31:0]           irq_mask_o,
    input wire logic                  irq_req_o
);
    // decoded accesses and the gated event condition
    wire logic ws = reg_sel_i && reg_wr_i && reg_addr_i == OIM_OFS_SET_PORT;
    wire logic wc = reg_sel_i && reg_wr_i && reg_addr_i == OIM_OFS_CLEAR_PORT;
    wire logic rd = reg_sel_i && !reg_wr_i && (reg_addr_i == OIM_OFS_SET_PORT || reg_addr_i == OIM_OFS_CLEAR_PORT);
    wire logic hot = irq_mask_o[31] && |(irq_mask_o[30:0] & {owner_change_event_i, 23'h0, irq_event_flags_i});
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    a_set_bits: assert property (ws |=> irq_mask_o == (($past(irq_mask_o) | $past(reg_wdata_i)) & OIM_IMPL_MASK))
        else $error("set port write gave wrong mask");
    a_clear_bits: assert property (wc |=> irq_mask_o == ($past(irq_mask_o) & ~$past(reg_wdata_i)))
        else $error("clear port write gave wrong mask");
    a_mask_holds: assert property (!(ws || wc) |=> $stable(irq_mask_o)) else $error("mask moved without write");
    a_read_back: assert property (rd |=> reg_rdata_o == $past(irq_mask_o)) else $error("read data not mask");
    a_req_level: assert property (1'b1 |=> irq_req_o == $past(hot)) else $error("request level wrong");
    a_gate_off: assert property (!irq_mask_o[31] |=> !irq_req_o) else $error("request with gate off");
    a_reset_zero: assert property ($rose(rst_b_i) |-> irq_mask_o == '0) else $error("mask not zero");
    a_hit_echo: assert property (1'b1 |=> reg_hit_o == $past(reg_sel_i)) else $error("hit not echoed");
    // main scenarios
    c_set: cover property (ws);
    c_clear: cover property (wc);
    c_read: cover property (rd);
    c_req: cover property ($rose(irq_req_o));
endmodule : oim_irq_mask_props
bind oim_irq_mask oim_irq_mask_props #(
    .NUM_EVENTS (NUM_EVENTS)
) u_oim_irq_mask_props (
    .clk_i                (clk_i),
    .rst_b_i              (rst_b_i),
    .reg_sel_i            (reg_sel_i),
    .reg_wr_i             (reg_wr_i),
    .reg_addr_i           (reg_addr_i),
    .reg_wdata_i          (reg_wdata_i),
    .reg_rdata_o          (reg_rdata_o),
    .reg_hit_o            (reg_hit_o),
    .owner_change_event_i (owner_change_event_i),
    .irq_event_flags_i    (irq_event_flags_i),
    .irq_mask_o           (irq_mask_o),
    .irq_req_o            (irq_req_o)
);
`default_nettype wire

// ---- verification/test_oim_irq_mask.sv ----
// test_oim_irq_mask: directed bench for the mask ports and request
// assumes the props checker is bound in; inputs change on falling edges
`timescale 1ns/1ps
`default_nettype none
module test_oim_irq_mask;
    import oim_pkg::*;
    logic        clk_i = 1'b0, rst_b_i = 1'b0, reg_sel_i = 1'b0, reg_wr_i = 1'b0, owner_change_event_i = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [6:0]  irq_event_flags_i = 7'h00;
    logic [31:0] reg_wdata_i = 32'h0, r;
    wire logic [31:0] reg_rdata_o, irq_mask_o;
    wire logic        reg_hit_o, irq_req_o;
    int num_errors = 0, checked = 0, cyc = 0;
    oim_irq_mask u_oim_irq_mask (
        .clk_i                (clk_i),
        .rst_b_i              (rst_b_i),
        .reg_sel_i            (reg_sel_i),
        .reg_wr_i             (reg_wr_i),
        .reg_addr_i           (reg_addr_i),
        .reg_wdata_i          (reg_wdata_i),
        .reg_rdata_o          (reg_rdata_o),
        .reg_hit_o            (reg_hit_o),
        .owner_change_event_i (owner_change_event_i),
        .irq_event_flags_i    (irq_event_flags_i),
        .irq_mask_o           (irq_mask_o),
        .irq_req_o            (irq_req_o)
    );
    task chk(input logic [31:0] g, e);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // one register access, read data kept in r
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(negedge clk_i);
        {reg_sel_i, reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, w, a, d};
        @(negedge clk_i);
        reg_sel_i = 1'b0;
        r = reg_rdata_o;
        chk(reg_hit_o, 32'h1);
    endtask : acc
    task t_ports;
        chk(irq_mask_o, 32'h0);
        acc(1'b1, OIM_OFS_SET_PORT, 32'hc000_007f);
        chk(irq_mask_o, 32'hc000_007f);
        acc(1'b1, OIM_OFS_CLEAR_PORT, 32'h4000_0055);
        chk(irq_mask_o, 32'h8000_002a);
        acc(1'b1, OIM_OFS_SET_PORT, 32'h0000_0001);
        chk(irq_mask_o, 32'h8000_002b);
        acc(1'b0, OIM_OFS_CLEAR_PORT, 32'h0);
        chk(r, 32'h8000_002b);
        chk(irq_mask_o, 32'h8000_002b);
        acc(1'b0, OIM_OFS_SET_PORT, 32'h0);
        chk(r, 32'h8000_002b);
        acc(1'b1, 8'h18, 32'h4000_0000);
        acc(1'b0, 8'h18, 32'h0);
        chk(r, 32'h0); // unmapped place reads zero
        chk(irq_mask_o, 32'h8000_002b); // unmapped place ignored
    endtask : t_ports
    // each enable alone, with other flags, own flag, then gate cleared
    task t_events;
        int b;
        for (int i = 0; i < 8; i++) begin
            b = (i == 7) ? 30 : i;
            acc(1'b1, OIM_OFS_CLEAR_PORT, 32'hc000_007f);
            acc(1'b1, OIM_OFS_SET_PORT, 32'h8000_0000 | (32'h1 << b));
            {owner_change_event_i, irq_event_flags_i} = {b != 30, ~(7'h1 << b)};
            acc(1'b0, OIM_OFS_SET_PORT, 32'h0);
            chk(irq_req_o, 32'h0);
            {owner_change_event_i, irq_event_flags_i} = {b == 30, 7'h1 << b};
            acc(1'b0, OIM_OFS_SET_PORT, 32'h0);
            chk(irq_req_o, 32'h1);
            // software clears the flag; the request must be low two edges later
            {owner_change_event_i, irq_event_flags_i} = 8'h00;
            repeat (2) @(negedge clk_i);
            chk(irq_req_o, 32'h0);
            {owner_change_event_i, irq_event_flags_i} = {b == 30, 7'h1 << b};
            acc(1'b1, OIM_OFS_CLEAR_PORT, 32'h8000_0000);
            // request lags the mask by one edge
            @(negedge clk_i);
            chk(irq_req_o, 32'h0);
            {owner_change_event_i, irq_event_flags_i} = 8'h00;
        end
    endtask : t_events
    task summarize;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    initial forever #2 clk_i = ~clk_i;
    // hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            num_errors++;
            summarize;
        end
    end
    initial begin
        repeat (3) @(negedge clk_i);
        rst_b_i = 1'b1;
        t_ports;
        t_events;
        summarize;
    end
endmodule : test_oim_irq_mask
`default_nettype wire
